// >>> design/dsa_pkg.sv
// Shared types and constants for the data-space access unit
package dsa_pkg;
	localparam int          DSA_AW         = 16;
	localparam int          DSA_DW         = 16;
	localparam int          DSA_RAM_WORDS  = 1024;
	localparam int          DSA_RAM_IW     = 10;
	localparam int          DSA_CRA_AW     = 11;
	localparam int          DSA_PW_AW      = 15;
	localparam int          DSA_REGION_LSB = 5;
	localparam int          DSA_REGION_W   = 6;
	localparam int          DSA_NEAR_W     = 13;
	localparam int          DSA_TOP_BIT    = 15;
	localparam logic [15:0] DSA_RAM_BASE   = 16'h0800;
	localparam logic [15:0] DSA_CRA_END    = 16'h0800;
	localparam logic [15:0] DSA_STEP_BYTE  = 16'h0001;
	localparam logic [15:0] DSA_STEP_WORD  = 16'h0002;
	localparam logic [15:0] DSA_ZERO_WORD  = 16'h0000;
	localparam logic [7:0]  DSA_ZERO_BYTE  = 8'h00;
	localparam logic [63:0] DSA_REGION_MAP = 64'h0c07_0000_07c7_173f;

	typedef enum logic [1:0]
	{
		DSA_MODE_IND     = 2'b00,
		DSA_MODE_IND_INC = 2'b01,
		DSA_MODE_NEAR    = 2'b10,
		DSA_MODE_FULL    = 2'b11
	} dsa_mode_t;

	typedef enum logic [1:0]
	{
		DSA_WIDEN_NONE = 2'b00,
		DSA_WIDEN_SIGN = 2'b01,
		DSA_WIDEN_ZERO = 2'b10
	} dsa_widen_t;

	typedef enum logic [1:0]
	{
		DSA_TGT_NONE = 2'b00,
		DSA_TGT_CRA  = 2'b01,
		DSA_TGT_RAM  = 2'b10,
		DSA_TGT_PWIN = 2'b11
	} dsa_tgt_t;

	typedef struct packed
	{
		logic        valid;
		dsa_mode_t   mode;
		logic        byte_op;
		logic [15:0] ptr;
		logic [15:0] lit;
	} dsa_gen_req_t;

	typedef struct packed
	{
		dsa_widen_t  widen;
		logic [15:0] dest_old;
	} dsa_rd_ctl_t;

	typedef struct packed
	{
		logic        rd;
		logic [10:0] addr;
	} dsa_cra_rd_t;

	typedef struct packed
	{
		logic [1:0]  be;
		logic [10:0] addr;
		logic [15:0] data;
	} dsa_cra_wr_t;
endpackage

// >>> design/dsa_top.sv
// Data-space address decode, byte lanes, memory and misalignment trap
`timescale 1ns/1ns

// Function
// - Effective addresses are sixteen bits and each selects one byte.
// - Address bit fifteen set routes the access to the program window.
// - Exactly 1024 words of data memory in the lower half.
// - Reads outside implemented areas return zero, byte or word.
// - Low byte at even address, high byte at the next odd address.
// - Post-increment advances pointer by one for bytes, two for words.
// - Byte read fetches the word, bit zero picks the byte, lands low.
// - Byte write strobes only the lane matching the address.
// - Word access at odd address raises an address error trap.
// - Misaligned read completes, misaligned write is suppressed, trap follows.
// - Byte load into a register keeps its high byte.
// - Sign widening extends bit seven; zero widening clears the high byte.
// - Near direct mode reaches 0000h to 1FFFh with thirteen bits.
// - Full-width direct mode uses a sixteen-bit address.
// - 0000h to 07FFh decodes as the control register area.
// - Unimplemented control register addresses read zero.
// - Control register decode is grouped in 32-byte regions.
// - Separate address generators for reads and writes.
module dsa_top
#(
	parameter logic [63:0] REGION_MAP = dsa_pkg::DSA_REGION_MAP,
	parameter logic [15:0] RAM_BASE   = dsa_pkg::DSA_RAM_BASE
)
(
	// Clock and reset
	input  wire logic                 REF_CLK_I,
	input  wire logic                 RST_I,
	// Read address generator
	input  wire dsa_pkg::dsa_gen_req_t RD_REQ_I,
	input  wire dsa_pkg::dsa_rd_ctl_t  RD_CTL_I,
	output logic [15:0]               RD_PTR_NEXT_O,
	output logic                      RD_DONE_O,
	output logic [15:0]               RD_DATA_O,
	output logic [15:0]               RD_DEST_O,
	// Write address generator
	input  wire dsa_pkg::dsa_gen_req_t WR_REQ_I,
	input  wire logic [15:0]          WR_DATA_I,
	output logic [15:0]               WR_PTR_NEXT_O,
	// Control register area
	output dsa_pkg::dsa_cra_rd_t      CRA_RD_O,
	output dsa_pkg::dsa_cra_wr_t      CRA_WR_O,
	input  wire logic [15:0]          CRA_RDATA_I,
	// Program window
	output logic                      PW_RD_O,
	output logic [14:0]               PW_ADDR_O,
	input  wire logic [15:0]          PW_RDATA_I,
	// Trap
	output logic                      ADDR_TRAP_O
);
	import dsa_pkg::*;

	// Byte lanes kept as two arrays so each has its own write line
	logic [7:0] ram_lo [DSA_RAM_WORDS];
	logic [7:0] ram_hi [DSA_RAM_WORDS];

	// Independent address generation for each side
	wire logic [15:0] rd_ea;
	wire logic [15:0] wr_ea;
	assign rd_ea = (RD_REQ_I.mode == DSA_MODE_NEAR) ? {3'b000, RD_REQ_I.lit[DSA_NEAR_W-1:0]} :
	               (RD_REQ_I.mode == DSA_MODE_FULL) ? RD_REQ_I.lit : RD_REQ_I.ptr;
	assign wr_ea = (WR_REQ_I.mode == DSA_MODE_NEAR) ? {3'b000, WR_REQ_I.lit[DSA_NEAR_W-1:0]} :
	               (WR_REQ_I.mode == DSA_MODE_FULL) ? WR_REQ_I.lit : WR_REQ_I.ptr;

	wire logic [15:0] rd_step;
	wire logic [15:0] wr_step;
	assign rd_step = RD_REQ_I.byte_op ? DSA_STEP_BYTE : DSA_STEP_WORD;
	assign wr_step = WR_REQ_I.byte_op ? DSA_STEP_BYTE : DSA_STEP_WORD;

	// Target decode, shared by both generators
	function automatic dsa_tgt_t dsa_decode(input logic [15:0] ea, input logic [63:0] map,
	                                        input logic [15:0] base);
		logic [15:0] ofs;
		ofs = ea - base;
		if (ea[DSA_TOP_BIT])
			dsa_decode = DSA_TGT_PWIN;
		else if (ea < DSA_CRA_END)
			dsa_decode = map[ea[DSA_REGION_LSB +: DSA_REGION_W]] ? DSA_TGT_CRA : DSA_TGT_NONE;
		else if (ea >= base && ofs[15:1] < 15'(DSA_RAM_WORDS))
			dsa_decode = DSA_TGT_RAM;
		else
			dsa_decode = DSA_TGT_NONE;
	endfunction

	wire dsa_tgt_t rd_tgt;
	wire dsa_tgt_t wr_tgt;
	assign rd_tgt = dsa_decode(rd_ea, REGION_MAP, RAM_BASE);
	assign wr_tgt = dsa_decode(wr_ea, REGION_MAP, RAM_BASE);

	wire logic rd_mis;
	wire logic wr_mis;
	assign rd_mis = !RD_REQ_I.byte_op && rd_ea[0];
	assign wr_mis = !WR_REQ_I.byte_op && wr_ea[0];

	// Stage one: access issued to the selected target
	logic        rd_v_reg;
	logic        rd_byte_reg;
	logic        rd_mis_reg;
	logic [15:0] rd_ea_reg;
	dsa_tgt_t    rd_tgt_reg;
	dsa_rd_ctl_t rd_ctl_reg;
	logic        wr_v_reg;
	logic        wr_byte_reg;
	logic        wr_mis_reg;
	logic [15:0] wr_ea_reg;
	dsa_tgt_t    wr_tgt_reg;
	logic [15:0] wr_data_reg;

	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			rd_v_reg      <= 1'b0;
			wr_v_reg      <= 1'b0;
			rd_byte_reg   <= 1'b0;
			wr_byte_reg   <= 1'b0;
			rd_mis_reg    <= 1'b0;
			wr_mis_reg    <= 1'b0;
			rd_ea_reg     <= DSA_ZERO_WORD;
			wr_ea_reg     <= DSA_ZERO_WORD;
			rd_tgt_reg    <= DSA_TGT_NONE;
			wr_tgt_reg    <= DSA_TGT_NONE;
			rd_ctl_reg    <= '0;
			wr_data_reg   <= DSA_ZERO_WORD;
			RD_PTR_NEXT_O <= DSA_ZERO_WORD;
			WR_PTR_NEXT_O <= DSA_ZERO_WORD;
		end
		else
		begin
			rd_v_reg      <= RD_REQ_I.valid;
			wr_v_reg      <= WR_REQ_I.valid;
			rd_byte_reg   <= RD_REQ_I.byte_op;
			wr_byte_reg   <= WR_REQ_I.byte_op;
			rd_mis_reg    <= rd_mis;
			wr_mis_reg    <= wr_mis;
			rd_ea_reg     <= rd_ea;
			wr_ea_reg     <= wr_ea;
			rd_tgt_reg    <= rd_tgt;
			wr_tgt_reg    <= wr_tgt;
			rd_ctl_reg    <= RD_CTL_I;
			wr_data_reg   <= WR_DATA_I;
			RD_PTR_NEXT_O <= (RD_REQ_I.mode == DSA_MODE_IND_INC) ? RD_REQ_I.ptr + rd_step : RD_REQ_I.ptr;
			WR_PTR_NEXT_O <= (WR_REQ_I.mode == DSA_MODE_IND_INC) ? WR_REQ_I.ptr + wr_step : WR_REQ_I.ptr;
		end
	end

	// Misaligned words still read the aligned word, so the read completes
	wire logic [DSA_RAM_IW-1:0] rd_idx;
	wire logic [DSA_RAM_IW-1:0] wr_idx;
	wire logic [15:0]           rd_ofs;
	wire logic [15:0]           wr_ofs;
	assign rd_ofs = rd_ea_reg - RAM_BASE;
	assign wr_ofs = wr_ea_reg - RAM_BASE;
	assign rd_idx = rd_ofs[DSA_RAM_IW:1];
	assign wr_idx = wr_ofs[DSA_RAM_IW:1];

	// Write lanes: byte writes touch one half only, bad words touch nothing
	wire logic       wr_go;
	wire logic [1:0] wr_be;
	assign wr_go = wr_v_reg && !wr_mis_reg;
	assign wr_be = !wr_go ? 2'b00 : !wr_byte_reg ? 2'b11 :
	               wr_ea_reg[0] ? 2'b10 : 2'b01;
	// The byte to be written is copied onto both halves of the write data
	wire logic [15:0] wr_lane_data;
	assign wr_lane_data = wr_byte_reg ? {wr_data_reg[7:0], wr_data_reg[7:0]} : wr_data_reg;

	assign CRA_RD_O.rd   = rd_v_reg && rd_tgt_reg == DSA_TGT_CRA;
	assign CRA_RD_O.addr = {rd_ea_reg[DSA_CRA_AW-1:1], 1'b0};
	// Unimplemented regions get no strobe at all
	assign CRA_WR_O.be   = (wr_tgt_reg == DSA_TGT_CRA) ? wr_be : 2'b00;
	assign CRA_WR_O.addr = {wr_ea_reg[DSA_CRA_AW-1:1], 1'b0};
	assign CRA_WR_O.data = wr_lane_data;
	assign PW_RD_O       = rd_v_reg && rd_tgt_reg == DSA_TGT_PWIN;
	assign PW_ADDR_O     = {rd_ea_reg[DSA_PW_AW-1:1], 1'b0};

	// Program window is read-only here; writes to it are dropped
	always_ff @(posedge REF_CLK_I)
	begin
		if (wr_tgt_reg == DSA_TGT_RAM && wr_be[0])
			ram_lo[wr_idx] <= wr_lane_data[7:0];
		if (wr_tgt_reg == DSA_TGT_RAM && wr_be[1])
			ram_hi[wr_idx] <= wr_lane_data[15:8];
	end

	// Read word and byte selection
	wire logic [15:0] rd_word;
	wire logic [7:0]  rd_sel;
	wire logic [15:0] rd_value;
	assign rd_word = (rd_tgt_reg == DSA_TGT_CRA)  ? CRA_RDATA_I :
	                 (rd_tgt_reg == DSA_TGT_RAM)  ? {ram_hi[rd_idx], ram_lo[rd_idx]} :
	                 (rd_tgt_reg == DSA_TGT_PWIN) ? PW_RDATA_I : DSA_ZERO_WORD;
	assign rd_sel   = rd_ea_reg[0] ? rd_word[15:8] : rd_word[7:0];
	assign rd_value = rd_byte_reg ? {DSA_ZERO_BYTE, rd_sel} : rd_word;

	// Register merge: byte loads keep the old high byte unless widened
	wire logic [15:0] rd_merge;
	assign rd_merge = !rd_byte_reg ? rd_word :
	                  (rd_ctl_reg.widen == DSA_WIDEN_SIGN) ? {{8{rd_sel[7]}}, rd_sel} :
	                  (rd_ctl_reg.widen == DSA_WIDEN_ZERO) ? {DSA_ZERO_BYTE, rd_sel} :
	                  {rd_ctl_reg.dest_old[15:8], rd_sel};

	wire logic trap_next;
	assign trap_next = (rd_v_reg && rd_mis_reg) || (wr_v_reg && wr_mis_reg);

	// Stage two: results and trap, one cycle after the access
	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			RD_DONE_O   <= 1'b0;
			RD_DATA_O   <= DSA_ZERO_WORD;
			RD_DEST_O   <= DSA_ZERO_WORD;
			ADDR_TRAP_O <= 1'b0;
		end
		else
		begin
			RD_DONE_O   <= rd_v_reg;
			RD_DATA_O   <= rd_value;
			RD_DEST_O   <= rd_merge;
			ADDR_TRAP_O <= trap_next;
		end
	end

	default clocking dsa_cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);

	sequence dsa_bad_write_s;
		WR_REQ_I.valid && !WR_REQ_I.byte_op && wr_ea[0];
	endsequence

	sequence dsa_bad_read_s;
		RD_REQ_I.valid && !RD_REQ_I.byte_op && rd_ea[0];
	endsequence

	trap_after_write_a: assert property (dsa_bad_write_s |=> CRA_WR_O.be == 2'b00 ##1 ADDR_TRAP_O)
		else $error("misaligned write not suppressed or trapped");
	trap_after_read_a: assert property (dsa_bad_read_s |-> ##2 (RD_DONE_O && ADDR_TRAP_O))
		else $error("misaligned read did not complete with trap");
	trap_cause_a: assert property (ADDR_TRAP_O |-> $past(trap_next))
		else $error("trap without misaligned access");
	ptr_step_a: assert property (RD_REQ_I.mode == DSA_MODE_IND_INC && RD_REQ_I.byte_op
		|=> RD_PTR_NEXT_O == $past(RD_REQ_I.ptr) + DSA_STEP_BYTE)
		else $error("byte post-increment step wrong");
	ptr_word_a: assert property (WR_REQ_I.mode == DSA_MODE_IND_INC && !WR_REQ_I.byte_op
		|=> WR_PTR_NEXT_O == $past(WR_REQ_I.ptr) + DSA_STEP_WORD)
		else $error("word post-increment step wrong");
	byte_lane_a: assert property (WR_REQ_I.valid && WR_REQ_I.byte_op && wr_tgt == DSA_TGT_CRA
		|=> CRA_WR_O.be == ($past(wr_ea[0]) ? 2'b10 : 2'b01))
		else $error("byte write lane wrong");
	unimpl_zero_a: assert property (RD_REQ_I.valid && rd_tgt == DSA_TGT_NONE |-> ##2 RD_DATA_O == DSA_ZERO_WORD)
		else $error("unimplemented read not zero");
	window_route_a: assert property (RD_REQ_I.valid && rd_ea[DSA_TOP_BIT] |=> PW_RD_O && !CRA_RD_O.rd)
		else $error("upper half not routed to program window");
	byte_keep_a: assert property (RD_REQ_I.valid && RD_REQ_I.byte_op && RD_CTL_I.widen == DSA_WIDEN_NONE
		|-> ##2 RD_DEST_O[15:8] == $past(RD_CTL_I.dest_old[15:8], 2))
		else $error("byte load changed high byte");
	near_reach_a: assert property (RD_REQ_I.valid && RD_REQ_I.mode == DSA_MODE_NEAR
		|=> rd_ea_reg < 16'h2000)
		else $error("near direct address beyond reach");
	// A misaligned read in the same cycle may trap legally, so it is excluded here
	unimpl_write_a: assert property (WR_REQ_I.valid && WR_REQ_I.byte_op && wr_tgt == DSA_TGT_NONE
		&& !(RD_REQ_I.valid && !RD_REQ_I.byte_op && rd_ea[0])
		|=> CRA_WR_O.be == 2'b00 ##1 !ADDR_TRAP_O)
		else $error("unimplemented write had an effect");

	sequence dsa_rd_byte_s;
		RD_REQ_I.valid && RD_REQ_I.byte_op;
	endsequence

	sequence dsa_rd_word_s;
		RD_REQ_I.valid && !RD_REQ_I.byte_op;
	endsequence

	sequence dsa_wr_cra_byte_s;
		WR_REQ_I.valid && WR_REQ_I.byte_op && wr_tgt == DSA_TGT_CRA;
	endsequence

	sequence dsa_rd_take_s;
		RD_REQ_I.valid;
	endsequence

	// Read completion timing, independent of target or alignment
	done_timing_a: assert property (dsa_rd_take_s |-> ##2 RD_DONE_O)
		else $error("read did not complete two cycles later");
	done_cause_a: assert property (RD_DONE_O |-> $past(RD_REQ_I.valid, 2))
		else $error("read done without a request");

	// Byte reads land on the low half; the merge keeps or widens the high half
	byte_low_a: assert property (dsa_rd_byte_s |-> ##2 RD_DATA_O[15:8] == DSA_ZERO_BYTE)
		else $error("byte read high half not zero");
	dest_low_a: assert property (dsa_rd_byte_s |-> ##2 RD_DEST_O[7:0] == RD_DATA_O[7:0])
		else $error("byte load low half differs from read byte");
	word_dest_a: assert property (dsa_rd_word_s |-> ##2 RD_DEST_O == RD_DATA_O)
		else $error("word load differs from read word");
	sign_widen_a: assert property (RD_REQ_I.valid && RD_REQ_I.byte_op && RD_CTL_I.widen == DSA_WIDEN_SIGN
		|-> ##2 RD_DEST_O[15:8] == {8{RD_DEST_O[7]}})
		else $error("sign widening wrong");
	zero_widen_a: assert property (RD_REQ_I.valid && RD_REQ_I.byte_op && RD_CTL_I.widen == DSA_WIDEN_ZERO
		|-> ##2 RD_DEST_O[15:8] == DSA_ZERO_BYTE)
		else $error("zero widening left high byte");

	// Address generation on both sides
	full_read_a: assert property (RD_REQ_I.valid && RD_REQ_I.mode == DSA_MODE_FULL
		|=> rd_ea_reg == $past(RD_REQ_I.lit))
		else $error("full direct read address wrong");
	full_write_a: assert property (WR_REQ_I.valid && WR_REQ_I.mode == DSA_MODE_FULL
		|=> wr_ea_reg == $past(WR_REQ_I.lit))
		else $error("full direct write address wrong");
	ptr_hold_a: assert property (RD_REQ_I.mode != DSA_MODE_IND_INC
		|=> RD_PTR_NEXT_O == $past(RD_REQ_I.ptr))
		else $error("pointer moved without post-increment");
	ptr_rd_word_a: assert property (RD_REQ_I.mode == DSA_MODE_IND_INC && !RD_REQ_I.byte_op
		|=> RD_PTR_NEXT_O == $past(RD_REQ_I.ptr) + DSA_STEP_WORD)
		else $error("read word post-increment step wrong");
	ptr_wr_byte_a: assert property (WR_REQ_I.mode == DSA_MODE_IND_INC && WR_REQ_I.byte_op
		|=> WR_PTR_NEXT_O == $past(WR_REQ_I.ptr) + DSA_STEP_BYTE)
		else $error("write byte post-increment step wrong");

	// Control area decode, reads of its gaps, and the program window address
	cra_decode_a: assert property (RD_REQ_I.valid && rd_ea < DSA_CRA_END
		&& REGION_MAP[rd_ea[DSA_REGION_LSB +: DSA_REGION_W]] |=> CRA_RD_O.rd)
		else $error("implemented region not strobed");
	cra_gap_a: assert property (RD_REQ_I.valid && rd_ea < DSA_CRA_END
		&& !REGION_MAP[rd_ea[DSA_REGION_LSB +: DSA_REGION_W]] |-> ##2 RD_DATA_O == DSA_ZERO_WORD)
		else $error("empty region read not zero");
	window_addr_a: assert property (RD_REQ_I.valid && rd_ea[DSA_TOP_BIT]
		|=> PW_ADDR_O == {$past(rd_ea[14:1]), 1'b0})
		else $error("program window address wrong");

	// Write lanes towards the control area
	word_lanes_a: assert property (WR_REQ_I.valid && !WR_REQ_I.byte_op && !wr_ea[0] && wr_tgt == DSA_TGT_CRA
		|=> CRA_WR_O.be == 2'b11)
		else $error("word write did not strobe both lanes");
	byte_data_a: assert property (dsa_wr_cra_byte_s |=> CRA_WR_O.data[7:0] == $past(WR_DATA_I[7:0])
		&& CRA_WR_O.data[15:8] == $past(WR_DATA_I[7:0]))
		else $error("byte write data not on both halves");
	other_no_cra_a: assert property (WR_REQ_I.valid && wr_tgt != DSA_TGT_CRA
		|=> CRA_WR_O.be == 2'b00)
		else $error("write outside control area strobed it");

	// A trap needs a misaligned word on one of the generators
	aligned_no_trap_a: assert property (!(RD_REQ_I.valid && !RD_REQ_I.byte_op && rd_ea[0])
		&& !(WR_REQ_I.valid && !WR_REQ_I.byte_op && wr_ea[0]) |-> ##2 !ADDR_TRAP_O)
		else $error("trap after aligned accesses");
endmodule

// >>> sim/dsa_periph_model.sv
// Peripheral register file and program window responder for the data-space access unit
`timescale 1ns/1ns
module dsa_periph_model
(
	// Clock
	input  wire logic                 clk_i,
	// Control register area
	input  wire dsa_pkg::dsa_cra_rd_t cra_rd_i,
	input  wire dsa_pkg::dsa_cra_wr_t cra_wr_i,
	output logic [15:0]               cra_rdata_o,
	// Program window
	input  wire logic                 pw_rd_i,
	input  wire logic [14:0]          pw_addr_i,
	output logic [15:0]               pw_rdata_o
);
	import dsa_pkg::*;
	logic [15:0] regs [0:1023];
	logic [15:0] junk_reg = 16'h3c5a;
	initial
	begin
		for (int i = 0; i < 1024; i++) regs[i] = 16'h0000;
	end
	// Idle reply changes every cycle so a stale sample never passes
	always @(posedge clk_i)
	begin
		junk_reg <= {junk_reg[14:0], junk_reg[15] ^ junk_reg[13]} + 16'h0101;
		if (cra_wr_i.be[0]) regs[cra_wr_i.addr[10:1]][7:0] <= cra_wr_i.data[7:0];
		if (cra_wr_i.be[1]) regs[cra_wr_i.addr[10:1]][15:8] <= cra_wr_i.data[15:8];
	end
	assign cra_rdata_o = cra_rd_i.rd ? regs[cra_rd_i.addr[10:1]] : junk_reg;
	assign pw_rdata_o  = pw_rd_i ? {pw_addr_i, 1'b1} : ~junk_reg;
endmodule

// >>> sim/data_space_access_unit_test.sv
// Self-checking bench for the data-space access unit
`timescale 1ns/1ns
module data_space_access_unit_test;
	import dsa_pkg::*;
	logic         clk;
	logic         rst;
	dsa_gen_req_t rd_req;
	dsa_gen_req_t wr_req;
	dsa_gen_req_t s_rd;
	dsa_gen_req_t s_wr;
	dsa_rd_ctl_t  rd_ctl;
	logic [15:0]  wr_data;
	logic [15:0]  rd_ptr_next;
	logic         rd_done;
	logic [15:0]  rd_data;
	logic [15:0]  rd_dest;
	logic [15:0]  wr_ptr_next;
	dsa_cra_rd_t  cra_rd;
	dsa_cra_wr_t  cra_wr;
	logic [15:0]  cra_rdata;
	logic         pw_rd;
	logic [14:0]  pw_addr;
	logic [15:0]  pw_rdata;
	logic         trap;
	logic [15:0]  mem_ref [0:2047];
	logic [31:0]  exp_q [$];
	logic [31:0]  e;
	logic [31:0]  rng = 32'he32b0c92;
	logic [15:0]  rx;
	logic [15:0]  ra;
	int           err_total = 0;
	int           n_checks = 0;
	int           exp_traps = 0;
	int           got_traps = 0;

	dsa_top dut (.REF_CLK_I(clk), .RST_I(rst), .RD_REQ_I(rd_req), .RD_CTL_I(rd_ctl), .RD_PTR_NEXT_O(rd_ptr_next),
		.RD_DONE_O(rd_done), .RD_DATA_O(rd_data), .RD_DEST_O(rd_dest), .WR_REQ_I(wr_req), .WR_DATA_I(wr_data),
		.WR_PTR_NEXT_O(wr_ptr_next), .CRA_RD_O(cra_rd), .CRA_WR_O(cra_wr), .CRA_RDATA_I(cra_rdata),
		.PW_RD_O(pw_rd), .PW_ADDR_O(pw_addr), .PW_RDATA_I(pw_rdata), .ADDR_TRAP_O(trap));
	dsa_periph_model periph (.clk_i(clk), .cra_rd_i(cra_rd), .cra_wr_i(cra_wr), .cra_rdata_o(cra_rdata),
		.pw_rd_i(pw_rd), .pw_addr_i(pw_addr), .pw_rdata_o(pw_rdata));

	function automatic logic [15:0] rnd16();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[15:0];
	endfunction
	function automatic logic [15:0] ea_of(dsa_gen_req_t r);
		if (r.mode == DSA_MODE_NEAR) return {3'h0, r.lit[12:0]};
		if (r.mode == DSA_MODE_FULL) return r.lit;
		return r.ptr;
	endfunction
	function automatic logic [15:0] ptr_of(dsa_gen_req_t r);
		if (r.mode != DSA_MODE_IND_INC) return r.ptr;
		return r.ptr + (r.byte_op ? DSA_STEP_BYTE : DSA_STEP_WORD);
	endfunction
	function automatic logic impl(logic [15:0] ea);
		return ea[15:11] == 5'h01 || (ea[15:11] == 5'h00 && DSA_REGION_MAP[ea[10:5]]);
	endfunction
	function automatic logic [15:0] ref_word(logic [15:0] ea);
		if (ea[15]) return {ea[14:1], 2'b01};
		return impl(ea) ? mem_ref[ea[11:1]] : DSA_ZERO_WORD;
	endfunction
	function automatic logic [1:0] be_of(dsa_gen_req_t r);
		logic [15:0] ea;
		ea = ea_of(r);
		if ((!r.byte_op && ea[0]) || ea[15:11] != 5'h00 || !DSA_REGION_MAP[ea[10:5]]) return 2'b00;
		return r.byte_op ? (ea[0] ? 2'b10 : 2'b01) : 2'b11;
	endfunction
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One access per cycle; a write is followed by an idle cycle so the RAM update lands first
	task automatic op(input logic wr, input dsa_mode_t m, input logic bo, input logic [15:0] a,
		input dsa_widen_t w, input logic [15:0] wd, input logic [15:0] old);
		dsa_gen_req_t r;
		logic [15:0]  ea;
		logic [15:0]  wv;
		logic [7:0]   b;
		r = '{valid: 1'b1, mode: m, byte_op: bo, ptr: a, lit: a};
		ea = ea_of(r);
		wv = ref_word(ea);
		b = ea[0] ? wv[15:8] : wv[7:0];
		if (!bo && ea[0]) exp_traps++;
		@(posedge clk);
		rd_req <= wr ? '0 : r;
		wr_req <= wr ? r : '0;
		wr_data <= wd;
		rd_ctl <= '{widen: w, dest_old: old};
		if (wr && (bo || !ea[0]) && impl(ea))
			mem_ref[ea[11:1]] = bo ? (ea[0] ? {wd[7:0], wv[7:0]} : {wv[15:8], wd[7:0]}) : wd;
		if (!wr)
			exp_q.push_back(bo ? {8'h00, b, w == DSA_WIDEN_SIGN ? {{8{b[7]}}, b} :
				w == DSA_WIDEN_ZERO ? {8'h00, b} : {old[15:8], b}} : {wv, wv});
		if (wr)
		begin
			@(posedge clk);
			wr_req <= '0;
		end
	endtask

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		$display("timeout");
		err_total++;
		end_sim();
	end
	always @(posedge clk)
	begin
		s_rd = rd_req;
		s_wr = wr_req;
		#1;
		if (!rst && s_rd.valid) chk("read pointer", ptr_of(s_rd), rd_ptr_next);
		if (!rst && s_wr.valid) chk("write pointer", ptr_of(s_wr), wr_ptr_next);
		if (!rst && s_wr.valid) chk("write lanes", {14'h0, be_of(s_wr)}, {14'h0, cra_wr.be});
		if (trap === 1'b1) got_traps++;
		if (rd_done === 1'b1 && exp_q.size() == 0) chk("spurious done", 16'h0000, 16'h0001);
		if (rd_done === 1'b1 && exp_q.size() != 0)
		begin
			e = exp_q.pop_front();
			chk("read data", e[31:16], rd_data);
			chk("read dest", e[15:0], rd_dest);
		end
	end
	initial
	begin
		rst = 1'b1;
		rd_req = '0;
		wr_req = '0;
		rd_ctl = '0;
		wr_data = 16'h0000;
		for (int i = 0; i < 2048; i++) mem_ref[i] = 16'h0000;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 1024; i++) op(1, DSA_MODE_FULL, 0, 16'h0800 + 16'(2 * i), DSA_WIDEN_NONE, rnd16(), 0);
		$display("test fill done");
		op(0, DSA_MODE_FULL, 0, 16'h0800, DSA_WIDEN_NONE, 0, 0);
		op(0, DSA_MODE_FULL, 0, 16'h0ffe, DSA_WIDEN_NONE, 0, 0);
		op(0, DSA_MODE_IND_INC, 1, 16'h0fff, DSA_WIDEN_NONE, 0, 16'h1234);
		op(0, DSA_MODE_FULL, 0, 16'h1000, DSA_WIDEN_NONE, 0, 0);
		op(0, DSA_MODE_IND, 1, 16'h1001, DSA_WIDEN_SIGN, 0, 0);
		op(0, DSA_MODE_FULL, 0, 16'h07e0, DSA_WIDEN_NONE, 0, 0);
		op(0, DSA_MODE_NEAR, 0, 16'he802, DSA_WIDEN_NONE, 0, 0);
		op(0, DSA_MODE_FULL, 0, 16'h8000, DSA_WIDEN_NONE, 0, 0);
		op(0, DSA_MODE_FULL, 1, 16'hffff, DSA_WIDEN_NONE, 0, 0);
		$display("test bounds done");
		op(1, DSA_MODE_FULL, 1, 16'h0801, DSA_WIDEN_NONE, 16'h7f80, 0);
		for (int k = 0; k < 3; k++) op(0, DSA_MODE_FULL, 1, 16'h0801, dsa_widen_t'(k), 0, 16'habcd);
		op(1, DSA_MODE_FULL, 0, 16'h0803, DSA_WIDEN_NONE, 16'h1234, 0);
		op(0, DSA_MODE_FULL, 0, 16'h0803, DSA_WIDEN_NONE, 0, 0);
		op(1, DSA_MODE_FULL, 0, 16'h07e0, DSA_WIDEN_NONE, 16'h5555, 0);
		op(0, DSA_MODE_FULL, 0, 16'h07e0, DSA_WIDEN_NONE, 0, 0);
		op(1, DSA_MODE_FULL, 1, 16'h0011, DSA_WIDEN_NONE, 16'h00c3, 0);
		op(0, DSA_MODE_FULL, 0, 16'h0010, DSA_WIDEN_NONE, 0, 0);
		$display("test lanes done");
		for (int i = 0; i < 400; i++)
		begin
			rx = rnd16();
			ra = rnd16();
			ra = rx[1:0] == 2'd0 ? {5'h00, ra[10:0]} : rx[1:0] == 2'd1 ? {5'h01, ra[10:0]} : ra;
			op(rx[2] & rx[3], dsa_mode_t'(rx[5:4]), rx[6], ra, dsa_widen_t'(rx[8:7] == 2'b11 ? 2'b00 : rx[8:7]),
				rnd16(), rnd16());
		end
		@(posedge clk);
		rd_req <= '0;
		repeat (4) @(posedge clk);
		for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge clk);
		chk("pending reads", 16'h0000, 16'(exp_q.size()));
		chk("trap count", 16'(exp_traps), 16'(got_traps));
		$display("test random done");
		end_sim();
	end
endmodule
